// ===== common/pwm_trig_defines.svh
`ifndef PWM_TRIG_DEFINES_SVH
`define PWM_TRIG_DEFINES_SVH

// register word indices; byte address is four times the index
`define PT_IDX_DEAD_TIME 4'h0
`define PT_IDX_CMP0 4'h1
`define PT_IDX_CMP1 4'h2
`define PT_IDX_CMP2 4'h3
`define PT_IDX_CMP3 4'h4
`define PT_IDX_TRIG_CTRL 4'h5
`define PT_IDX_TRIG_OUT 4'h6
`define PT_IDX_LINE_SEL 4'h7
`define PT_IDX_MODE_SEL 4'h8
`define PT_IDX_STATUS 4'h9

// field positions
`define PT_MODE_STRIDE 4
`define PT_SYNC_LSB 16
`define PT_OUT_MODE_BIT 0
`define PT_EMG_EN_BIT 1
`define PT_VE_SEL_BIT 0
`define PT_BUF_SRC_BIT 1

// reset values
`define PT_RST_WORD 32'h0000_0000
`define PT_RST_WAIT 1'b1

// trigger timing mode codes
`define PT_TM_MATCH_UP 3'h0
`define PT_TM_MATCH_DOWN 3'h1
`define PT_TM_MATCH_BOTH 3'h2
`define PT_TM_PEAK 3'h3
`define PT_TM_BOTTOM 3'h4
`define PT_TM_PEAK_BOTTOM 3'h5

// update sync select codes
`define PT_SYNC_BY_MODE 2'h0
`define PT_SYNC_BOTTOM 2'h1
`define PT_SYNC_PEAK 2'h2

// timing: dead time unit in ns and system clock period in ns
`define PT_DT_UNIT_NS 200
`define PT_CLK_PERIOD_NS 10
`define PT_DT_UNIT_CYCLES \
  ((`PT_DT_UNIT_NS + `PT_CLK_PERIOD_NS - 1) / `PT_CLK_PERIOD_NS)

// number of selectable trigger output lines
`define PT_LINE_COUNT 6

`endif

// ===== common/pwm_trig_pkg.sv
package pwm_trig_pkg;

  // dead time phase states, one-hot
  typedef enum logic [2:0] {
    DT_UPPER = 3'b001,
    DT_GAP = 3'b010,
    DT_LOWER = 3'b100
  } dt_state_t;

  typedef struct packed {
    dt_state_t st;
    logic target;
    logic [15:0] cnt;
    logic up;
    logic lo;
  } dt_t;

  typedef struct packed {
    logic [15:0] active;
  } chan_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] sync;
  } chan_cfg_t;

  // carrier events and levels; peak and bottom are one cycle wide, down, saw and run are levels
  typedef struct packed {
    logic fresh;
    logic peak;
    logic bottom;
    logic down;
    logic saw;
    logic run;
  } carrier_t;

  typedef struct packed {
    logic [7:0] dead_time;
    logic [3:0][15:0] cmp;
    logic [3:0][2:0] mode;
    logic [1:0] sync;
    logic out_mode;
    logic emg_en;
    logic [2:0] line_sel;
    logic ve_sel;
    logic buf_src;
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] prev_count;
    logic [3:0] trig;
    logic [5:0] line;
  } ctl_t;

endpackage

// ===== src/dead_time_phase.sv
`timescale 1ns/1ps
`include "pwm_trig_defines.svh"
module dead_time_phase #(
  parameter int UNIT_CYCLES = `PT_DT_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [7:0] dead_time,
  input wire logic demand,
  // gate drives
  output logic upper,
  output logic lower
);

  pwm_trig_pkg::dt_t s;
  pwm_trig_pkg::dt_t n;
  logic [15:0] gap_m1;

  // the gap count must fit its 16-bit counter for the largest setting
  if (UNIT_CYCLES < 1 || UNIT_CYCLES * 255 > 65535) begin : g_chk
    $error("dead_time_phase: UNIT_CYCLES out of range");
  end

  // gap length minus one, at least one cycle of both off
  always_comb begin
    gap_m1 = 16'(32'(dead_time) * UNIT_CYCLES);
    if (gap_m1 != 16'h0000) begin
      gap_m1 = gap_m1 - 16'h0001;
    end
  end

  // any change of demand first drops both sides, then waits the gap
  always_comb begin
    n = s;
    case (s.st)
      pwm_trig_pkg::DT_UPPER, pwm_trig_pkg::DT_LOWER: begin
        if (demand != s.target) begin
          n.st = pwm_trig_pkg::DT_GAP;
          n.target = demand;
          n.cnt = gap_m1;
        end
      end
      pwm_trig_pkg::DT_GAP: begin
        if (demand != s.target) begin
          n.target = demand;
          n.cnt = gap_m1;
        end else if (s.cnt == 16'h0000) begin
          n.st = s.target ? pwm_trig_pkg::DT_UPPER
                          : pwm_trig_pkg::DT_LOWER;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end
      default: begin
        n.st = pwm_trig_pkg::DT_GAP;
      end
    endcase
    n.up = (n.st == pwm_trig_pkg::DT_UPPER);
    n.lo = (n.st == pwm_trig_pkg::DT_LOWER);
  end

  // state register; both sides off out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= pwm_trig_pkg::DT_GAP;
    end else begin
      s <= n;
    end
  end

  assign upper = s.up;
  assign lower = s.lo;

endmodule

// ===== src/pwm_sync_trigger_deadtime.sv
`timescale 1ns/1ps
`include "pwm_trig_defines.svh"
module pwm_sync_trigger_deadtime #(
  parameter int LINE_COUNT = `PT_LINE_COUNT,
  parameter int DT_UNIT_CYCLES = `PT_DT_UNIT_CYCLES
) (
  // system
  input wire logic CLK_SYS,
  input wire logic RST,
  // avalon-mm slave, byte address
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // carrier state from the pwm unit, same clock
  input wire logic [15:0] PWM_COUNT,
  input wire logic [15:0] PWM_PERIOD,
  input wire logic PWM_COUNT_DOWN,
  input wire logic CARRIER_SHAPE_SELECT,
  input wire logic PWM_RUN_ENABLE,
  input wire logic EMERGENCY_PROTECTION,
  // vector engine compare values
  input wire logic [15:0] VECTOR_ENGINE_TRIGGER_COMPARE_ZERO,
  input wire logic [15:0] VECTOR_ENGINE_TRIGGER_COMPARE_ONE,
  // per phase demand, 1 asks for upper on
  input wire logic [2:0] PHASE_DEMAND,
  // gate drives
  output logic [2:0] UPPER_OUT,
  output logic [2:0] LOWER_OUT,
  // adc start pulses
  output logic [3:0] ADC_TRIGGER,
  output logic [5:0] TRIGGER_LINE
);

  pwm_trig_pkg::ctl_t s;
  pwm_trig_pkg::ctl_t n;
  pwm_trig_pkg::carrier_t car;
  pwm_trig_pkg::chan_cfg_t [3:0] cfg;
  logic [3:0][15:0] src;
  logic [3:0] hit;
  logic [3:0] pending;
  logic [3:0] ev;
  logic allow;
  logic req;
  logic [3:0] idx;
  logic [31:0] rd;
  logic [31:0] w;

  // the line vector is six wide; fewer lines are allowed, more are not
  if (LINE_COUNT < 1 || LINE_COUNT > 6) begin : g_chk
    $error("pwm_sync_trigger_deadtime: LINE_COUNT out of range");
  end

  // merge write data into the old word by byte enable
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // carrier events; a count that holds still raises nothing twice
  always_comb begin
    car.fresh = (PWM_COUNT != s.prev_count);
    car.peak = car.fresh && (PWM_COUNT == PWM_PERIOD);
    car.bottom = car.fresh && (PWM_COUNT == 16'h0000);
    car.down = PWM_COUNT_DOWN;
    car.saw = !CARRIER_SHAPE_SELECT;
    car.run = PWM_RUN_ENABLE;
  end

  // compare sources: vector engine may own the first two
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      src[i] = s.cmp[i];
      cfg[i].mode = s.mode[i];
      cfg[i].sync = s.sync;
    end
    if (s.ve_sel) begin
      src[0] = VECTOR_ENGINE_TRIGGER_COMPARE_ZERO;
      src[1] = VECTOR_ENGINE_TRIGGER_COMPARE_ONE;
    end
  end

  // one channel per trigger, identical apart from its inputs
  for (genvar i = 0; i < 4; i++) begin : g_chan
    trigger_channel u_chan (
      .clk(CLK_SYS),
      .rst(RST),
      .src_cmp(src[i]),
      .xfer_en(!s.buf_src),
      .cfg(cfg[i]),
      .car(car),
      .count(PWM_COUNT),
      .hit(hit[i]),
      .pending(pending[i])
    );
  end

  // dead time for the three phase pairs
  for (genvar p = 0; p < 3; p++) begin : g_phase
    dead_time_phase #(
      .UNIT_CYCLES(DT_UNIT_CYCLES)
    ) u_dt (
      .clk(CLK_SYS),
      .rst(RST),
      .dead_time(s.dead_time),
      .demand(PHASE_DEMAND[p]),
      .upper(UPPER_OUT[p]),
      .lower(LOWER_OUT[p])
    );
  end

  // register read view of the current state
  always_comb begin
    rd = `PT_RST_WORD;
    case (idx)
      `PT_IDX_DEAD_TIME: rd[7:0] = s.dead_time;
      `PT_IDX_CMP0: rd[15:0] = s.cmp[0];
      `PT_IDX_CMP1: rd[15:0] = s.cmp[1];
      `PT_IDX_CMP2: rd[15:0] = s.cmp[2];
      `PT_IDX_CMP3: rd[15:0] = s.cmp[3];
      `PT_IDX_TRIG_CTRL: begin
        for (int i = 0; i < 4; i++) begin
          rd[`PT_MODE_STRIDE*i +: 3] = s.mode[i];
        end
        rd[`PT_SYNC_LSB +: 2] = s.sync;
      end
      `PT_IDX_TRIG_OUT: begin
        rd[`PT_OUT_MODE_BIT] = s.out_mode;
        rd[`PT_EMG_EN_BIT] = s.emg_en;
      end
      `PT_IDX_LINE_SEL: rd[2:0] = s.line_sel;
      `PT_IDX_MODE_SEL: begin
        rd[`PT_VE_SEL_BIT] = s.ve_sel;
        rd[`PT_BUF_SRC_BIT] = s.buf_src;
      end
      `PT_IDX_STATUS: begin
        rd[3:0] = pending;
        rd[4] = EMERGENCY_PROTECTION;
        rd[5] = PWM_RUN_ENABLE;
      end
      default: rd = `PT_RST_WORD;
    endcase
  end

  // bus decode and merged write word
  always_comb begin
    req = AVS_READ || AVS_WRITE;
    idx = AVS_ADDRESS[5:2];
    w = merge(rd, AVS_WRITEDATA, AVS_BYTEENABLE);
  end

  // next state: bus slave, register writes and trigger routing
  always_comb begin
    n = s;
    n.prev_count = PWM_COUNT;
    // one wait cycle, then the answer; a write lands on the answer edge
    if (req && s.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = rd;
    end else begin
      n.waitreq = `PT_RST_WAIT;
    end
    if (AVS_WRITE && !s.waitreq) begin
      case (idx)
        `PT_IDX_DEAD_TIME: n.dead_time = w[7:0];
        `PT_IDX_CMP0: n.cmp[0] = w[15:0];
        `PT_IDX_CMP1: n.cmp[1] = w[15:0];
        `PT_IDX_CMP2: n.cmp[2] = w[15:0];
        `PT_IDX_CMP3: n.cmp[3] = w[15:0];
        `PT_IDX_TRIG_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            n.mode[i] = w[`PT_MODE_STRIDE*i +: 3];
          end
          n.sync = w[`PT_SYNC_LSB +: 2];
        end
        `PT_IDX_TRIG_OUT: begin
          n.out_mode = w[`PT_OUT_MODE_BIT];
          n.emg_en = w[`PT_EMG_EN_BIT];
        end
        `PT_IDX_LINE_SEL: n.line_sel = w[2:0];
        `PT_IDX_MODE_SEL: begin
          n.ve_sel = w[`PT_VE_SEL_BIT];
          n.buf_src = w[`PT_BUF_SRC_BIT];
        end
        default: n.dead_time = s.dead_time; // unmapped or read-only
      endcase
    end
    // emergency state mutes the triggers unless software allows them
    allow = !EMERGENCY_PROTECTION || s.emg_en;
    ev = allow ? hit : 4'h0;
    n.trig = ev;
    n.line = 6'h00;
    if (s.out_mode) begin
      n.trig[0] = 1'b0;
      if (32'(s.line_sel) < LINE_COUNT) begin
        n.line[s.line_sel] = ev[0];
      end
    end
  end

  // all state in one register; waitrequest stands high in reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.waitreq <= `PT_RST_WAIT;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign AVS_READDATA = s.rdata;
  assign AVS_WAITREQUEST = s.waitreq;
  assign ADC_TRIGGER = s.trig;
  assign TRIGGER_LINE = s.line;

endmodule

// ===== src/trigger_channel.sv
`timescale 1ns/1ps
`include "pwm_trig_defines.svh"
module trigger_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // first stage value and configuration
  input wire logic [15:0] src_cmp,
  input wire logic xfer_en,
  input wire pwm_trig_pkg::chan_cfg_t cfg,
  // carrier
  input wire pwm_trig_pkg::carrier_t car,
  input wire logic [15:0] count,
  // results
  output logic hit,
  output logic pending
);

  pwm_trig_pkg::chan_t s;
  pwm_trig_pkg::chan_t n;
  logic upd_peak;
  logic upd_bot;
  logic immed;
  logic match;
  logic up_hit;
  logic dn_hit;

  // second stage load timing
  always_comb begin
    upd_peak = 1'b0;
    upd_bot = 1'b0;
    immed = 1'b0;
    case (cfg.sync)
      `PT_SYNC_BY_MODE: begin
        case (cfg.mode)
          3'h1: upd_peak = 1'b1;
          3'h2: upd_bot = 1'b1;
          3'h3: begin
            upd_peak = 1'b1;
            upd_bot = 1'b1;
          end
          default: immed = 1'b1;
        endcase
      end
      `PT_SYNC_BOTTOM: upd_bot = 1'b1;
      `PT_SYNC_PEAK: upd_peak = 1'b1;
      default: begin
        upd_peak = 1'b1;
        upd_bot = 1'b1;
      end
    endcase
    // a sawtooth has no true peak/bottom pair; both collapse to peak
    if (car.saw && upd_peak && upd_bot) begin
      upd_bot = 1'b0;
    end
    n = s;
    if (xfer_en && (immed || !car.run
        || (upd_peak && car.peak) || (upd_bot && car.bottom))) begin
      n.active = src_cmp;
    end
  end

  // match against the active stage only
  always_comb begin
    match = car.fresh && (count == s.active);
    up_hit = match && (car.saw || !car.down);
    dn_hit = match && !car.saw && car.down;
    case (cfg.mode)
      `PT_TM_MATCH_UP: hit = up_hit;
      `PT_TM_MATCH_DOWN: hit = dn_hit;
      `PT_TM_MATCH_BOTH: hit = up_hit || dn_hit;
      `PT_TM_PEAK: hit = car.peak;
      `PT_TM_BOTTOM: hit = car.bottom;
      `PT_TM_PEAK_BOTTOM: hit = car.peak || car.bottom;
      default: hit = 1'b0;
    endcase
    pending = (s.active != src_cmp);
  end

  // second stage register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule

// ===== test/carrier_model.sv
`timescale 1ns/1ps
module carrier_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // shape: 0 sawtooth, 1 triangle
  input wire logic [15:0] period,
  input wire logic shape,
  // carrier state
  output logic [15:0] count,
  output logic down
);
  // free running carrier; triangle turns at period and at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      down <= 1'b0;
    end else if (!down && count >= period) begin
      count <= shape ? count - 16'h0001 : 16'h0000;
      down <= shape;
    end else if (down && count == 16'h0000) begin
      count <= 16'h0001;
      down <= 1'b0;
    end else begin
      count <= down ? count - 16'h0001 : count + 16'h0001;
    end
  end
endmodule

// ===== test/pwm_trig_assertions.sv
`timescale 1ns/1ps
module pwm_trig_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // bus handshake
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // carrier, demand and outputs
  input wire logic [15:0] PWM_COUNT,
  input wire logic [2:0] PHASE_DEMAND,
  input wire logic [2:0] UPPER_OUT,
  input wire logic [2:0] LOWER_OUT,
  input wire logic [3:0] ADC_TRIGGER,
  input wire logic [5:0] TRIGGER_LINE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // a pulse must trace back to a count that had just moved
  sequence s_fresh;
    $past(PWM_COUNT) != $past(PWM_COUNT, 2);
  endsequence
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence

  a_bus_answer: assert property (s_req |=> !AVS_WAITREQUEST)
    else $error("bus request not answered");
  a_bus_idle: assert property (!(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_bus_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer wider than one cycle");
  a_trig_fresh: assert property (|ADC_TRIGGER |-> s_fresh)
    else $error("trigger without fresh count");
  a_line_onehot: assert property ($onehot0(TRIGGER_LINE))
    else $error("several trigger lines at once");
  a_line_excl: assert property (|TRIGGER_LINE |-> !ADC_TRIGGER[0])
    else $error("trigger zero on both paths");
  a_dt_apart: assert property ((UPPER_OUT & LOWER_OUT) == 3'b000)
    else $error("upper and lower on together");
  a_dt_gap: assert property ($changed(PHASE_DEMAND) |=> ((UPPER_OUT | LOWER_OUT)
    & ($past(PHASE_DEMAND) ^ $past(PHASE_DEMAND, 2))) == 3'b000)
    else $error("no gap after demand change");
endmodule

bind pwm_sync_trigger_deadtime pwm_trig_checker chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PWM_COUNT(PWM_COUNT),
  .PHASE_DEMAND(PHASE_DEMAND), .UPPER_OUT(UPPER_OUT),
  .LOWER_OUT(LOWER_OUT), .ADC_TRIGGER(ADC_TRIGGER),
  .TRIGGER_LINE(TRIGGER_LINE));

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst = 1'b1, rd = 1'b0, wr = 1'b0, shp = 1'b1, dn, wrq;
  logic run = 1'b0, emergency_protection = 1'b0;
  logic [2:0] dem = 3'b000, up, lo;
  logic [3:0] trig;
  logic [5:0] adr = 6'h00, line, lines;
  logic [7:0] dts[2] = '{8'h00, 8'h03};
  logic [15:0] cnt, at0, ve0 = 16'h0003, ve1 = 16'h0005;
  logic [31:0] wd = 32'h0000_0000, q, rv;
  int mismatches = 0, num_checks = 0, nline, hits[4];
  int tri_exp[8] = '{1, 1, 2, 1, 1, 2, 0, 0};
  int saw_exp[8] = '{1, 0, 1, 1, 1, 2, 0, 0};
  int sync_at[4] = '{8, 4, 8, 8};

  // dead-time unit of two cycles keeps the gaps short
  pwm_sync_trigger_deadtime #(.DT_UNIT_CYCLES(2)) uut (
    .CLK_SYS(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(q), .AVS_WAITREQUEST(wrq), .PWM_COUNT(cnt),
    .PWM_PERIOD(16'h000a), .PWM_COUNT_DOWN(dn),
    .CARRIER_SHAPE_SELECT(shp), .PWM_RUN_ENABLE(run),
    .EMERGENCY_PROTECTION(emergency_protection), .VECTOR_ENGINE_TRIGGER_COMPARE_ZERO(ve0),
    .VECTOR_ENGINE_TRIGGER_COMPARE_ONE(ve1), .PHASE_DEMAND(dem),
    .UPPER_OUT(up), .LOWER_OUT(lo), .ADC_TRIGGER(trig),
    .TRIGGER_LINE(line));
  carrier_model carrier (.clk(clk), .rst(rst), .period(16'h000a),
    .shape(shp), .count(cnt), .down(dn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wrq !== 1'b0 && n < 40);
    rv = q;
    wr <= 1'b0;
    rd <= 1'b0;
    chk(32'(n >= 40), 32'h0);
  endtask

  task automatic rdchk(input logic [3:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(rv, e);
  endtask

  task automatic ctrl(input logic [1:0] s, input logic [2:0] m);
    bus(1'b1, 4'h5, {14'h0000, s, {4{1'b0, m}}});
  endtask

  // counts pulses over w cycles; two edges pass first, since a second
  // stage reload lands one cycle after the write and the match in that
  // cycle still uses the old value
  task automatic watch(input int w);
    logic [15:0] prev;
    repeat (2) @(posedge clk);
    prev = cnt;
    hits = '{default: 0};
    nline = 0;
    lines = 6'h00;
    at0 = 16'hffff;
    repeat (w) begin
      @(posedge clk);
      for (int i = 0; i < 4; i++) hits[i] += int'(trig[i] === 1'b1);
      nline += int'(line !== 6'h00);
      lines |= line;
      if (trig[0] === 1'b1 && at0 === 16'hffff) at0 = prev;
      prev = cnt;
    end
  endtask

  task automatic t_regs;
    rdchk(4'h0, 32'h0000_0000);
    rdchk(4'h1, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'hffff_ffff);
    rdchk(4'h0, 32'h0000_00ff);
    bus(1'b1, 4'h1, 32'habcd_0007);
    rdchk(4'h1, 32'h0000_0007);
    rdchk(4'hf, 32'h0000_0000);
    $display("regs done");
  endtask

  task automatic t_dead;
    int n;
    logic want;
    foreach (dts[j]) begin
      bus(1'b1, 4'h0, {24'h00_0000, dts[j]});
      want = !dem[1];
      dem[1] <= want;
      n = 0;
      repeat (100) begin
        if ((want ? up[1] : lo[1]) === 1'b1) break;
        @(posedge clk);
        n += int'(up[1] === 1'b0 && lo[1] === 1'b0);
      end
      chk(n, dts[j] == 8'h00 ? 32'h1 : 32'(dts[j]) * 32'h2);
      chk({up[1], lo[1]}, want ? 2'b10 : 2'b01);
    end
    $display("dead done");
  endtask

  task automatic t_modes;
    for (int s = 0; s < 2; s++) begin
      shp <= s[0];
      repeat (25) @(posedge clk);
      for (int m = 0; m < 8; m++) begin
        ctrl(2'b00, 3'(m));
        watch(s ? 20 : 11);
        for (int i = 0; i < 4; i++)
          chk(hits[i], s ? tri_exp[m] : saw_exp[m]);
      end
    end
    $display("modes done");
  endtask

  task automatic t_gates;
    ctrl(2'b00, 3'h0);
    emergency_protection <= 1'b1;
    watch(20);
    chk(hits[0] + hits[3], 0);
    bus(1'b1, 4'h6, 32'h0000_0002);
    watch(20);
    chk(hits[0] + hits[3], 2);
    emergency_protection <= 1'b0;
    bus(1'b1, 4'h6, 32'h0000_0001);
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 4'h7, 32'(s));
      watch(20);
      chk(hits[0], 0);
      chk(lines, s < 6 ? 32'h1 << s : 32'h0);
      chk(nline, s < 6);
    end
    bus(1'b1, 4'h6, 32'h0000_0000);
    $display("gates done");
  endtask

  task automatic t_buffer;
    bus(1'b1, 4'h8, 32'h0000_0002);
    bus(1'b1, 4'h1, 32'h0000_0007);
    watch(20);
    chk(at0, 16'h0002);
    rdchk(4'h9, 32'h0000_0001);
    bus(1'b1, 4'h8, 32'h0000_0000);
    watch(20);
    chk(at0, 16'h0007);
    bus(1'b1, 4'h8, 32'h0000_0001);
    watch(20);
    chk(at0, ve0);
    rdchk(4'h1, 32'h0000_0007);
    bus(1'b1, 4'h8, 32'h0000_0000);
    $display("buffer done");
  endtask

  task automatic t_sync;
    int k;
    for (int s = 0; s < 4; s++) begin
      run <= 1'b0;
      bus(1'b1, 4'h1, 32'h0000_0004);
      ctrl(2'(s), 3'h1);
      run <= 1'b1;
      k = 0;
      while (k < 50 && !(cnt === 16'h0001 && dn === 1'b0)) begin
        @(posedge clk);
        k++;
      end
      bus(1'b1, 4'h1, 32'h0000_0008);
      watch(20);
      chk(at0, sync_at[s]);
    end
    run <= 1'b0;
    // sawtooth, peak-or-bottom sync: the write lands just before a bottom,
    // which must not load it; the old compare fires first
    shp <= 1'b0;
    bus(1'b1, 4'h1, 32'h0000_0004);
    ctrl(2'b11, 3'h0);
    run <= 1'b1;
    k = 0;
    while (k < 50 && !(cnt === 16'h0007 && dn === 1'b0)) begin
      @(posedge clk);
      k++;
    end
    bus(1'b1, 4'h1, 32'h0000_0002);
    watch(20);
    chk(at0, 16'h0004);
    run <= 1'b0;
    $display("sync done");
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence; compares stay within one to period minus one
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_dead;
    for (int i = 0; i < 4; i++)
      bus(1'b1, 4'(i + 1), 32'(i + 2));
    t_modes;
    t_gates;
    t_buffer;
    t_sync;
    tally_and_finish;
  end

  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #500_000;
    mismatches++;
    tally_and_finish;
  end
endmodule
